/* File: dv/fcu_chk_sva.sv */
// Port-level assertions for the fast counter unit.
module fcu_chk_sva (
   // Clock and reset.
   input wire logic                  core_clk,
   input wire logic                  rst_b,
   // Register port.
   input wire fcu_pkg::fcu_bus_req_t bus_req,
   input wire logic [31:0]           rd_data,
   // Field side.
   input wire logic [3:0]            in_line,
   input wire logic [1:0]            pwm_level,
   input wire logic                  output_line_1,
   input wire logic                  output_line_2
);
   timeunit 1ns;
   timeprecision 1ps;
   import fcu_pkg::*;
   logic [5:0]  ocfg_q;
   logic [31:0] pre1_q;
   logic        pre2_q;
   logic [2:0]  md1_q;
   logic [2:0]  md2_q;
   logic        cpr0_q;
   logic        clr1_q;
   logic [2:0]  age_q;
   wire  [2:0]  age_d = bus_req.wr ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
   wire         settled = age_q == 3'h7;
   wire         cmp1 = settled && ocfg_q[1:0] == OSEL_CMP;
   wire         cmp2 = settled && ocfg_q[3:2] == OSEL_CMP;

   ////////////////////////////////////////////////////////////////////////
   // Shadow copies of the written configuration.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         {ocfg_q, pre1_q, pre2_q, md1_q, md2_q, cpr0_q, clr1_q} <= '0;
         age_q <= 3'h0;
      end else begin
         age_q <= age_d;
         if (bus_req.wr) begin
            case (bus_req.addr)
               REG_OUTCFG:  ocfg_q <= bus_req.wdata[5:0];
               REG_PRESET0: pre1_q <= bus_req.wdata;
               8'h24:       pre2_q <= |bus_req.wdata;
               REG_CFG0:    md1_q <= bus_req.wdata[2:0];
               8'h04:       md2_q <= bus_req.wdata[2:0];
               REG_CPR0:    cpr0_q <= |bus_req.wdata;
               REG_CLEAR:   clr1_q <= bus_req.wdata[0];
               default:     ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   rd_idle_a: assert property (!$past(bus_req.rd) |-> rd_data == 32'h0)
      else $error("read data outside its cycle");
   unmapped_rd_a: assert property ($past(bus_req.rd)
      && $past(bus_req.addr) > 8'h3F |-> rd_data == 32'h0)
      else $error("unmapped read not zero");
   prog_out1_a: assert property (settled && ocfg_q[1:0] == OSEL_PROG
      |-> output_line_1 == ocfg_q[4]) else $error("output 1 not program bit");
   prog_out2_a: assert property (settled && ocfg_q[3:2] == OSEL_PROG
      |-> output_line_2 == ocfg_q[5]) else $error("output 2 not program bit");
   pwm_out2_a: assert property ((settled && ocfg_q[3:2] == OSEL_PWM
      && pwm_level[1]) [*3] |-> output_line_2)
      else $error("output 2 not following pulse source");
   zero_pre1_a: assert property (cmp1 && pre1_q == 32'h0
      |-> !output_line_1) else $error("zero preset output 1 high");
   zero_pre2_a: assert property (cmp2 && !pre2_q |-> !output_line_2)
      else $error("zero preset output 2 high");
   cmp_high1_a: assert property ($past(bus_req.rd)
      && $past(bus_req.addr) == REG_ACC0 && cmp1 && md1_q == MODE_TOTAL
      && !cpr0_q && !clr1_q && pre1_q != 32'h0 && rd_data >= pre1_q
      |-> ##[0:2] output_line_1) else $error("compare output 1 low");
   cmp_off2_a: assert property (cmp2 && md2_q != MODE_TOTAL
      |-> !output_line_2) else $error("compare output 2 without totalizer");

   cmp_hit_c: cover property (ocfg_q[1:0] == OSEL_CMP && output_line_1);
   pwm_hit_c: cover property (ocfg_q[3:2] == OSEL_PWM && output_line_2);
   acc_rd_c: cover property ($past(bus_req.rd) && rd_data != 32'h0);
endmodule // fcu_chk_sva

bind fcu_top fcu_chk_sva u_chk (
   .core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
   .in_line(in_line), .pwm_level(pwm_level),
   .output_line_1(output_line_1), .output_line_2(output_line_2));

/* File: dv/fcu_enc_model.sv */
// Behavioural encoder and pulse source on the four field inputs.
module fcu_enc_model (
   // Clock.
   input wire logic core_clk,
   // Field lines.
   output logic [3:0] lines
);
   timeunit 1ns;
   timeprecision 1ps;
   initial lines = 4'h0;

   // One line change after an edge, then a settle gap.
   task automatic put(input int i, input logic v, input int gap);
      @(posedge core_clk);
      lines[i] <= v;
      repeat (gap) @(posedge core_clk);
   endtask
   // Full pulses on one line.
   task automatic pls(input int i, input int n);
      repeat (n) begin
         put(i, 1'b1, 8);
         put(i, 1'b0, 8);
      end
   endtask
   // Gray steps on a phase pair; forward means phase A leads.
   task automatic quad(input int a, input bit fwd, input int n);
      repeat (n) begin
         if ((lines[a] == lines[a+1]) == fwd)
            put(a, !lines[a], 8);
         else
            put(a + 1, !lines[a+1], 8);
      end
   endtask
   // Marker pulse with no phase edge inside it.
   task automatic mark(input int i);
      put(i, 1'b1, 8);
      put(i, 1'b0, 8);
   endtask
endmodule // fcu_enc_model

/* File: dv/tb_top.sv */
// Self-checking bench for the fast counter unit.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fcu_pkg::*;
   logic         core_clk;
   logic         rst_b;
   fcu_bus_req_t req;
   logic [31:0]  rd_data;
   logic [3:0]   in_line;
   logic [1:0]   pwm_level;
   logic         out1;
   logic         out2;
   int           err_count = 0;
   int           n_compared = 0;
   int           win [4] = '{10, 20, 50, 100};

   fcu_top #(.WIN0_US(10), .WIN1_US(20), .WIN2_US(50), .WIN3_US(100)) dut (
      .core_clk(core_clk), .rst_b(rst_b), .bus_req(req), .rd_data(rd_data),
      .in_line(in_line), .pwm_level(pwm_level),
      .output_line_1(out1), .output_line_2(out2));
   fcu_enc_model enc (.core_clk(core_clk), .lines(in_line));

   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("errors %0d compared %0d", err_count, n_compared);
      if (err_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, lo, hi, input string m);
      n_compared++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         err_count++;
         $display("unexpected at %0t: %s got %0d", $time, m, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge core_clk);
      req <= '0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge core_clk);
      req <= '0;
      #1 d = rd_data;
      @(posedge core_clk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] lo, hi);
      logic [31:0] d;
      rd(a, d);
      chk(d, lo, hi, "register read");
   endtask
   task automatic poll(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      d = ~e;
      for (int k = 0; k < 5000 && d !== e; k++)
         rd(a, d);
      chk(d, e, e, "poll");
      if (d !== e) stop_test();
   endtask
   task automatic oc(input logic [1:0] e);
      repeat (8) @(posedge core_clk);
      chk({30'h0, out2, out1}, e, e, "outputs");
   endtask
   function automatic logic [31:0] c(logic [2:0] m, logic p, logic [1:0] s,
                                     logic [4:0] k);
      return {21'h0, k, s, p, m};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rc(REG_CFG0, 0, 0);
      wr(8'h14, 32'h1234_5678);
      rc(8'h14, 32'h1234_5678, 32'h1234_5678);
      wr(8'h44, 32'hFFFF_FFFF);
      rc(8'h44, 0, 0);
   endtask
   task automatic t_total();
      wr(REG_CFG0, c(MODE_TOTAL, 1'b0, 2'h0, 5'h0));
      enc.pls(0, 3);
      rc(REG_ACC0, 3, 3);
      wr(REG_CPR0, 32'h4);
      enc.pls(0, 2);
      rc(REG_ACC0, 1, 1);
      wr(REG_CFG0, c(MODE_TOTAL, 1'b1, 2'h0, 5'h0));
      enc.put(0, 1'b1, 8);
      rc(REG_ACC0, 1, 1);
      enc.put(0, 1'b0, 8);
      rc(REG_ACC0, 2, 2);
      wr(REG_CPR0, 32'h0);
      wr(REG_PRESET0, 32'h4);
      wr(REG_OUTCFG, 32'h0A);
      oc(2'b00);
      enc.pls(0, 2);
      rc(REG_ACC0, 4, 4);
      oc(2'b01);
      wr(REG_PRESET0, 32'h0);
      oc(2'b00);
      wr(REG_OUTCFG, 32'h14);
      pwm_level <= 2'b10;
      oc(2'b11);
      pwm_level <= 2'b00;
      oc(2'b01);
      wr(REG_CLEAR, 32'h1);
      enc.pls(0, 1);
      rc(REG_ACC0, 0, 0);
      wr(REG_CLEAR, 32'h0);
   endtask
   task automatic t_hwres();
      wr(8'h08, c(MODE_TRESET, 1'b0, 2'h0, 5'h0));
      enc.pls(0, 2);
      rc(REG_ACC0, 2, 2);
      enc.put(2, 1'b1, 0);
      poll(REG_ACC0, 0);
      enc.put(2, 1'b0, 8);
      wr(8'h08, 32'h0);
   endtask
   task automatic t_pulse();
      logic v;
      for (int s = 0; s < 4; s++) begin
         v = !s[0];
         wr(8'h04, c(MODE_PULSE, 1'b0, 2'(s), 5'h0));
         enc.put(1, !v, 20);
         enc.put(1, v, 400);
         enc.put(1, !v, 400);
         enc.put(1, v, 400);
         enc.put(1, !v, 20);
         rc(8'h34, s < 2 ? 3 : 7, s < 2 ? 5 : 9);
      end
   endtask
   task automatic t_freq();
      for (int s = 0; s < 4; s++) begin
         wr(8'h0C, c(MODE_FREQ, 1'b0, 2'(s), 5'h0));
         fork
            repeat (3 * win[s]) begin
               enc.put(3, 1'b1, 49);
               enc.put(3, 1'b0, 49);
            end
            begin
               repeat (250 * win[s]) @(posedge core_clk);
               rc(8'h3C, 900000, 1100000);
            end
         join
      end
   endtask
   task automatic t_quad();
      wr(REG_CFG0, c(MODE_QUAD, 1'b0, 2'h0, 5'h0));
      wr(REG_CLEAR, 32'h1);
      wr(REG_CLEAR, 32'h0);
      rc(REG_ACC0, 0, 0);
      enc.quad(0, 1'b1, 8);
      rc(REG_ACC0, 8, 8);
      enc.quad(0, 1'b0, 3);
      rc(REG_ACC0, 5, 5);
      wr(REG_CPR0, 32'h6);
      enc.quad(0, 1'b1, 1);
      rc(REG_ACC0, 0, 0);
      enc.quad(0, 1'b0, 1);
      rc(REG_ACC0, 5, 5);
      wr(REG_CLEAR, 32'h1);
      wr(REG_CLEAR, 32'h2);
      wr(REG_CLEAR, 32'h0);
      rc(REG_ACC0, 5, 5);
      wr(REG_CFG0, c(MODE_QUAD, 1'b1, 2'h0, 5'h0));
      enc.quad(0, 1'b1, 2);
      rc(REG_ACC0, 3, 3);
      wr(8'h08, c(MODE_MARKER, 1'b0, 2'h0, {3'h0, MK_ASYNC_RISE}));
      enc.mark(2);
      rc(REG_ACC0, 0, 0);
      wr(8'h08, c(MODE_MARKER, 1'b0, 2'h0, 5'h1C));
      enc.put(2, 1'b1, 8);
      enc.quad(0, 1'b0, 1);
      rc(REG_ACC0, 5, 5);
      enc.put(2, 1'b0, 8);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      rst_b = 1'b0;
      req = '0;
      pwm_level = 2'h0;
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      t_regs();
      t_total();
      t_hwres();
      t_pulse();
      t_freq();
      t_quad();
      stop_test();
   end
   initial begin
      repeat (100000) @(posedge core_clk);
      err_count++;
      stop_test();
   end
endmodule // tb_top

/* File: src/fcu_pkg.sv */
// Constants, types and register map of the fast counter unit.
// Overview of operation
// R1 - Four input channels count frequency, totals, pulses or quadrature.
// R2 - Frequency mode writes hertz to the accumulator; four window widths.
// R3 - Totalize mode counts once per selected edge, rising or falling.
// R4 - A nonzero revolution count N wraps the totalizer from N - 1 to zero.
// R5 - A held clear bit forces and holds the matching totalizer at zero.
// R6 - Inputs 3 and 4 reset totalizers 1 and 2 on a chosen edge.
// R7 - A hardware totalizer reset completes within 100 us of its edge.
// R8 - Output 1 or 2 goes high once totalizer 1 or 2 reaches the preset.
// R9 - Each output selects program bit, pulse width source or compare result.
// R10 - Presets may change at run time; a zero preset holds the output low.
// R11 - Width sub-modes hold the last high or low time in microseconds.
// R12 - Period sub-modes time rise to rise or fall to fall in microseconds.
// R13 - Quadrature on channel 1 uses inputs 1 and 2; channel 3 uses 3 and 4.
// R14 - A direction bit chooses up or down counting when input 1 leads.
// R15 - Every edge of both phases counts, giving four counts per cycle.
// R16 - Quadrature wraps between zero and count minus one both ways.
// R17 - Clear bits zero quadrature counters; set bits load count minus one.
// R18 - Input 3 as marker resets quadrature 1 to zero or count minus one.
// R19 - Async marker modes clear on marker rising, falling or both edges.
// R20 - Sync marker modes load on a phase edge while the marker level matches.
// R21 - The marker is sampled within 50 us of the quadrature edge.
// R22 - The encoder keeps a marker pulse within one selected quadrature edge.
// R23 - Inputs are synchronised; a one microsecond tick times pulses.
package fcu_pkg;

   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned TICK_NS       = 1000;
   localparam int unsigned TICK_CYC      =
      (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned NUM_CH        = 4;
   localparam int unsigned ACC_W         = 32;
   localparam int unsigned US_PER_S      = 1000000;

   // Frequency sample windows in microseconds.
   localparam int unsigned WIN0_US = 10000;
   localparam int unsigned WIN1_US = 100000;
   localparam int unsigned WIN2_US = 500000;
   localparam int unsigned WIN3_US = 1000000;

   // Channel modes.
   localparam logic [2:0] MODE_OFF    = 3'h0;
   localparam logic [2:0] MODE_FREQ   = 3'h1;
   localparam logic [2:0] MODE_TOTAL  = 3'h2;
   localparam logic [2:0] MODE_PULSE  = 3'h3;
   localparam logic [2:0] MODE_QUAD   = 3'h4;
   localparam logic [2:0] MODE_TRESET = 3'h5;
   localparam logic [2:0] MODE_MARKER = 3'h6;

   // Pulse sub-modes.
   localparam logic [1:0] PULSE_WHIGH = 2'h0;
   localparam logic [1:0] PULSE_WLOW  = 2'h1;
   localparam logic [1:0] PULSE_PRISE = 2'h2;
   localparam logic [1:0] PULSE_PFALL = 2'h3;

   // Output source selections.
   localparam logic [1:0] OSEL_PROG = 2'h0;
   localparam logic [1:0] OSEL_PWM  = 2'h1;
   localparam logic [1:0] OSEL_CMP  = 2'h2;

   // Marker mode field: sync flag, level, phase, edge or async edge.
   localparam int unsigned MK_SYNC = 4;
   localparam int unsigned MK_HIGH = 3;
   localparam int unsigned MK_PHB  = 2;
   localparam int unsigned MK_FALL = 1;
   localparam logic [1:0]  MK_ASYNC_RISE = 2'h0;
   localparam logic [1:0]  MK_ASYNC_FALL = 2'h1;
   localparam logic [1:0]  MK_ASYNC_BOTH = 2'h2;

   // Register byte offsets.
   localparam logic [7:0] REG_CFG0    = 8'h00;
   localparam logic [7:0] REG_CPR0    = 8'h10;
   localparam logic [7:0] REG_PRESET0 = 8'h20;
   localparam logic [7:0] REG_OUTCFG  = 8'h28;
   localparam logic [7:0] REG_CLEAR   = 8'h2C;
   localparam logic [7:0] REG_ACC0    = 8'h30;

   // Output configuration field positions.
   localparam int unsigned OUTCFG_SEL1_LSB = 0;
   localparam int unsigned OUTCFG_SEL2_LSB = 2;
   localparam int unsigned OUTCFG_PROG_LSB = 4;
   localparam int unsigned OUTCFG_W        = 6;
   localparam int unsigned CFG_W           = 11;

   // Reset values.
   localparam logic [10:0] CFG_RST    = 11'h000;
   localparam logic [31:0] CPR_RST    = 32'h0000_0000;
   localparam logic [31:0] PRESET_RST = 32'h0000_0000;
   localparam logic [5:0]  OUTCFG_RST = 6'h00;
   localparam logic [3:0]  CLEAR_RST  = 4'h0;

   typedef struct packed {
      logic [4:0] marker;
      logic [1:0] sel;
      logic       pol;
      logic [2:0] mode;
   } fcu_cfg_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } fcu_bus_req_t;

endpackage

/* File: src/fcu_top.sv */
// Fast counter unit: four input counter channels and two compare outputs.
module fcu_top #(
   parameter int unsigned WIN0_US = fcu_pkg::WIN0_US,
   parameter int unsigned WIN1_US = fcu_pkg::WIN1_US,
   parameter int unsigned WIN2_US = fcu_pkg::WIN2_US,
   parameter int unsigned WIN3_US = fcu_pkg::WIN3_US
) (
   // Clock and reset.
   input  wire logic                 core_clk,
   input  wire logic                 rst_b,
   // Register port.
   input  wire fcu_pkg::fcu_bus_req_t bus_req,
   output logic [31:0]               rd_data,
   // Field inputs and pulse width sources.
   input  wire logic [3:0]           in_line,
   input  wire logic [1:0]           pwm_level,
   // Physical outputs.
   output logic                      output_line_1,
   output logic                      output_line_2
);
   import fcu_pkg::*;

   localparam int unsigned TICK_W = $clog2(TICK_CYC);
   localparam logic [31:0] WIN_LIM [4] = '{32'(WIN0_US - 1),
      32'(WIN1_US - 1), 32'(WIN2_US - 1), 32'(WIN3_US - 1)};
   localparam logic [31:0] WIN_SCALE [4] = '{32'(US_PER_S / WIN0_US),
      32'(US_PER_S / WIN1_US), 32'(US_PER_S / WIN2_US),
      32'(US_PER_S / WIN3_US)};

   ////////////////////////////////////////////////////////////////////////
   // Helpers.

   // True when the address falls on one of n words starting at base.
   function automatic logic in_range(input logic [7:0] a,
                                     input logic [7:0] base,
                                     input logic [3:0] n);
      in_range = (a >= base) && (a < base + {2'b00, n, 2'b00})
                 && (a[1:0] == 2'b00);
   endfunction

   // Quadrature step: bit 1 is valid, bit 0 is up for input 1 leading.
   function automatic logic [1:0] quad_step(input logic ra,
                                            input logic fa,
                                            input logic rb,
                                            input logic fb,
                                            input logic a,
                                            input logic b);
      logic up;
      logic dn;
      logic both;
      up = (ra & ~b) | (a & rb) | (fa & b) | (~a & fb);
      dn = (ra & b) | (a & fb) | (fa & ~b) | (~a & rb);
      both = (ra | fa) & (rb | fb);
      quad_step = {(up | dn) & ~both, up};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers and microsecond tick.

   logic [3:0]        sync1_q;
   logic [3:0]        sync2_q;
   logic [3:0]        prev_q;
   logic [TICK_W-1:0] tick_cnt_q;
   logic              tick_q;
   wire  [3:0]        rise_w = sync2_q & ~prev_q;
   wire  [3:0]        fall_w = ~sync2_q & prev_q;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
         prev_q  <= 4'h0;
      end else begin
         sync1_q <= in_line; // R23
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == TICK_W'(TICK_CYC - 1)) begin
         tick_cnt_q <= '0; // R23
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + TICK_W'(1);
         tick_q     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file.

   fcu_cfg_t             cfg_q [NUM_CH];
   logic [31:0]          cpr_q [NUM_CH];
   logic [31:0]          preset_q [2];
   logic [OUTCFG_W-1:0]  outcfg_q;
   logic [3:0]           clear_q;
   logic [ACC_W-1:0]     acc_q [NUM_CH];
   logic [31:0]          rd_d;

   wire [7:0] addr_w    = bus_req.addr;
   wire [1:0] idx_w     = addr_w[3:2];
   wire       hit_cfg   = in_range(addr_w, REG_CFG0, 4'(NUM_CH));
   wire       hit_cpr   = in_range(addr_w, REG_CPR0, 4'(NUM_CH));
   wire       hit_pre   = in_range(addr_w, REG_PRESET0, 4'h2);
   wire       hit_acc   = in_range(addr_w, REG_ACC0, 4'(NUM_CH));
   wire       hit_out   = (addr_w == REG_OUTCFG);
   wire       hit_clr   = (addr_w == REG_CLEAR);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int k = 0; k < NUM_CH; k++) begin
            cfg_q[k] <= fcu_cfg_t'(CFG_RST);
            cpr_q[k] <= CPR_RST;
         end
         preset_q[0] <= PRESET_RST;
         preset_q[1] <= PRESET_RST;
         outcfg_q    <= OUTCFG_RST;
         clear_q     <= CLEAR_RST;
      end else if (bus_req.wr) begin
         if (hit_cfg) begin
            cfg_q[idx_w] <= fcu_cfg_t'(bus_req.wdata[CFG_W-1:0]);
         end
         if (hit_cpr) begin
            cpr_q[idx_w] <= bus_req.wdata;
         end
         if (hit_pre) begin
            preset_q[addr_w[2]] <= bus_req.wdata; // R10
         end
         if (hit_out) begin
            outcfg_q <= bus_req.wdata[OUTCFG_W-1:0];
         end
         if (hit_clr) begin
            clear_q <= bus_req.wdata[3:0];
         end
      end
   end

   always_comb begin
      rd_d = 32'h0000_0000;
      if (hit_cfg) begin
         rd_d = {21'h000000, cfg_q[idx_w]};
      end else if (hit_cpr) begin
         rd_d = cpr_q[idx_w];
      end else if (hit_pre) begin
         rd_d = preset_q[addr_w[2]];
      end else if (hit_out) begin
         rd_d = {26'h0000000, outcfg_q};
      end else if (hit_clr) begin
         rd_d = {28'h0000000, clear_q};
      end else if (hit_acc) begin
         rd_d = acc_q[idx_w];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= 32'h0000_0000;
      end else begin
         rd_data <= bus_req.rd ? rd_d : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter channels.

   logic [2:0] eff_mode [NUM_CH];

   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch // R1
      localparam int JB = (i % 2 == 0) ? i + 1 : i;
      localparam int JR = (i < 2) ? i + 2 : i;

      logic [ACC_W-1:0] acc_d;
      logic [31:0]      meas_q;
      logic [31:0]      meas_d;
      logic [31:0]      win_q;
      logic [31:0]      win_d;
      logic             started_q;
      logic             started_d;

      // A pair partner running quadrature takes this input over.
      wire taken_w = (i % 2 == 1) && (cfg_q[i-(i%2)].mode == MODE_QUAD);
      wire odd_quad_w = (i % 2 == 1) && (cfg_q[i].mode == MODE_QUAD);
      assign eff_mode[i] = (taken_w || odd_quad_w) ? MODE_OFF
                                                   : cfg_q[i].mode; // R13

      wire [31:0] cpr_m1_w  = cpr_q[i] - 32'h0000_0001;
      wire        cpr_nz_w  = (cpr_q[i] != 32'h0000_0000);
      wire        at_top_w  = cpr_nz_w && (acc_q[i] == cpr_m1_w);
      wire [1:0]  sel_w     = cfg_q[i].sel;
      wire        tot_edge_w = cfg_q[i].pol ? fall_w[i] : rise_w[i]; // R3
      wire        clr_w     = clear_q[i];
      wire        set_w     = (i % 2 == 0) && clear_q[JB];

      // Hardware reset from input 3 or 4, edge of chosen polarity.
      wire hw_rst_w = (i < 2) && (cfg_q[JR].mode == MODE_TRESET)
         && (cfg_q[JR].pol ? fall_w[JR] : rise_w[JR]); // R6 R7

      // Quadrature step on phases A and B.
      wire [1:0] step_w = quad_step(rise_w[i], fall_w[i], rise_w[JB],
                                    fall_w[JB], sync2_q[i], sync2_q[JB]);
      wire       up_w   = step_w[0] ^ cfg_q[i].pol; // R14

      // Marker on input 3 for quadrature 1.
      wire [4:0] mk_w    = cfg_q[2].marker;
      wire       mk_en_w = (i == 0) && (cfg_q[2].mode == MODE_MARKER); // R18
      wire       mk_any_w = rise_w[2] | fall_w[2];
      wire       mk_async_w = !mk_w[MK_SYNC] && (
         (mk_w[1:0] == MK_ASYNC_RISE && rise_w[2]) ||
         (mk_w[1:0] == MK_ASYNC_FALL && fall_w[2]) ||
         (mk_w[1:0] == MK_ASYNC_BOTH && mk_any_w)); // R19
      wire       ph_rise_w = mk_w[MK_PHB] ? rise_w[JB] : rise_w[i];
      wire       ph_fall_w = mk_w[MK_PHB] ? fall_w[JB] : fall_w[i];
      // The marker level is taken in the same cycle as the phase edge.
      wire       lvl_ok_w = mk_w[MK_SYNC]
                            && (sync2_q[2] == mk_w[MK_HIGH]); // R21 R22
      wire       mk_zero_w = lvl_ok_w && (mk_w[MK_FALL] ? ph_fall_w
                                                        : ph_rise_w);
      wire       mk_top_w  = lvl_ok_w && (mk_w[MK_FALL] ? ph_rise_w
                                                        : ph_fall_w);

      // Pulse start and store edges per sub-mode.
      wire start_w = (sel_w == PULSE_WHIGH || sel_w == PULSE_PRISE)
                     ? rise_w[i] : fall_w[i];
      wire stop_w  = (sel_w == PULSE_WLOW || sel_w == PULSE_PRISE)
                     ? rise_w[i] : fall_w[i];

      always_comb begin
         acc_d     = acc_q[i];
         meas_d    = meas_q;
         win_d     = win_q;
         started_d = started_q;
         case (eff_mode[i])
            MODE_FREQ: begin
               started_d = 1'b0;
               if (rise_w[i]) begin
                  meas_d = meas_q + 32'h0000_0001;
               end
               if (tick_q) begin
                  if (win_q >= WIN_LIM[sel_w]) begin
                     acc_d  = meas_d * WIN_SCALE[sel_w]; // R2
                     meas_d = 32'h0000_0000;
                     win_d  = 32'h0000_0000;
                  end else begin
                     win_d = win_q + 32'h0000_0001;
                  end
               end
            end
            MODE_TOTAL: begin
               meas_d    = 32'h0000_0000;
               win_d     = 32'h0000_0000;
               started_d = 1'b0;
               if (tot_edge_w) begin
                  acc_d = at_top_w ? '0 : acc_q[i] + 32'h0000_0001; // R4
               end
               if (hw_rst_w || clr_w) begin
                  acc_d = '0; // R5 R6
               end
            end
            MODE_PULSE: begin
               win_d = 32'h0000_0000;
               if (tick_q && meas_q != 32'hFFFF_FFFF) begin
                  meas_d = meas_q + 32'h0000_0001; // R11 R12
               end
               if (stop_w && started_q) begin
                  acc_d = meas_q; // R11 R12
               end
               if (start_w) begin
                  meas_d    = 32'h0000_0000;
                  started_d = 1'b1;
               end
            end
            MODE_QUAD: begin
               meas_d    = 32'h0000_0000;
               win_d     = 32'h0000_0000;
               started_d = 1'b0;
               if (step_w[1]) begin // R15
                  if (up_w) begin
                     acc_d = at_top_w ? '0 : acc_q[i] + 32'h0000_0001;
                  end else if (cpr_nz_w && acc_q[i] == '0) begin
                     acc_d = cpr_m1_w; // R16
                  end else begin
                     acc_d = acc_q[i] - 32'h0000_0001; // R16
                  end
               end
               if (mk_en_w && (mk_async_w || mk_zero_w)) begin
                  acc_d = '0; // R18 R19 R20
               end else if (mk_en_w && mk_top_w) begin
                  acc_d = cpr_m1_w; // R20
               end
               if (set_w) begin
                  acc_d = cpr_m1_w; // R17
               end
               if (clr_w) begin
                  acc_d = '0; // R17
               end
            end
            default: begin
               acc_d     = '0;
               meas_d    = 32'h0000_0000;
               win_d     = 32'h0000_0000;
               started_d = 1'b0;
            end
         endcase
      end

      always_ff @(posedge core_clk or negedge rst_b) begin
         if (!rst_b) begin
            acc_q[i]  <= '0;
            meas_q    <= 32'h0000_0000;
            win_q     <= 32'h0000_0000;
            started_q <= 1'b0;
         end else begin
            acc_q[i]  <= acc_d;
            meas_q    <= meas_d;
            win_q     <= win_d;
            started_q <= started_d;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output selection and preset compare.

   logic [1:0] out_q;

   for (genvar k = 0; k < 2; k++) begin : g_out
      wire [1:0] osel_w = outcfg_q[OUTCFG_SEL1_LSB + 2*k +: 2];
      wire cmp_w = (eff_mode[k] == MODE_TOTAL)
                   && (preset_q[k] != 32'h0000_0000)
                   && (acc_q[k] >= preset_q[k]); // R8 R10
      logic out_d;

      always_comb begin
         case (osel_w) // R9
            OSEL_PROG: out_d = outcfg_q[OUTCFG_PROG_LSB + k];
            OSEL_PWM:  out_d = pwm_level[k];
            OSEL_CMP:  out_d = cmp_w; // R8
            default:   out_d = 1'b0;
         endcase
      end

      always_ff @(posedge core_clk or negedge rst_b) begin
         if (!rst_b) begin
            out_q[k] <= 1'b0;
         end else begin
            out_q[k] <= out_d;
         end
      end
   end

   assign output_line_1 = out_q[0];
   assign output_line_2 = out_q[1];

endmodule // fcu_top
